//--- hw/fir_decimation_chain_regs.svh
/*
 * Register offsets, field positions, reset values and sizes of the FIR chain.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef FIR_DECIMATION_CHAIN_REGS_SVH
`define FIR_DECIMATION_CHAIN_REGS_SVH

// ************
// Register addresses (5-bit control-interface addresses)
// ************
`define ADDR_FIR1_CTRL 5'h0A
`define ADDR_FIR2_CTRL 5'h0B
`define ADDR_GAIN_PDN 5'h0C
`define ADDR_DAC 5'h0D
`define ADDR_FIR2_SHIFT 5'h0E

// ************
// Field positions
// ************
`define FIR1_MODE_LSB 14
`define FIR1_NC_LSB 6
`define FIR1_BASE_LSB 0
`define FIR2_MODE_LSB 14
`define FIR2_NC_LSB 7
`define FIR2_BASE_LSB 0
`define FIR2_ILV_BIT 0
`define FIR2_SHA_LSB 4
`define FIR2_SHB_LSB 8
`define GAIN_LSB 2
`define PDN_BIT 0

// ************
// Reset values and sizes
// ************
`define RST_REG16 16'h0000
`define RST_GAIN 3'h0
`define FIR1_DEPTH 64
`define FIR2_DEPTH 128
`define DAC_FRAME_BITS 5'h10
`define FIR_SCALE 15

`endif

//--- hw/fir_decimation_chain_pkg.sv
/*
 * Types of the FIR decimation chain.
 * Assumes the register header sits in the include path.
 */
package fir_decimation_chain_pkg;

   typedef enum logic [1:0]
   {
      RESP_ODD = 2'h0,
      RESP_EVEN = 2'h1,
      RESP_HALFBAND = 2'h2,
      RESP_ARBITRARY = 2'h3
   } response_type;

   typedef enum {ST_IDLE, ST_RUN, ST_DONE} mac_state_type;

   typedef enum logic [2:0]
   {
      GAIN_1_00 = 3'h0,
      GAIN_1_14 = 3'h4,
      GAIN_1_33 = 3'h2,
      GAIN_1_60 = 3'h6,
      GAIN_2_00 = 3'h1,
      GAIN_2_67 = 3'h5,
      GAIN_4_00 = 3'h3
   } pga_gain_type;

endpackage

//--- hw/fir_decimation_chain.sv
/*
 * Two decimate-by-two FIR stages, DAC value select, gain/power-down word.
 * Assumes synchronous register and coefficient writes, one-cycle sample
 * valid pulses and a one-cycle serial bit enable.
 */
// Behaviour
// - Stage one decimates CIC output by two
// - Response field picks odd/even/halfband/arbitrary
// - Stage one coefficients: bank zero, 64 words
// - Control write switches set, no reload
// - Length follows response type and tap count
// - Stage-one sample memory covers 62 taps
// - One coefficient per clock, ascending order
// - Odd: newest/oldest pairs, centre alone
// - Stage one scales by two to fifteen
// - Stage two memories 128 deep, wider fields
// - Independent A/B shifts after fifteen
// - A and B run together, banks 1/2
// - A and B share type, count, base
// - Interleave: A and B weights summed into one filter, B equals A
// - Latest DAC write from either path wins
// - Gain code in bits 4..2
// - Bit 0 selects power-down
// - Serial DAC word 16 bits, low 12 used
`timescale 1ns/1ns
`include "fir_decimation_chain_regs.svh"

module fir_decimation_chain
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic reg_wr_in,
   input wire logic [4:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   input wire logic coef_wr_in,
   input wire logic [1:0] coef_bank_in,
   input wire logic [6:0] coef_addr_in,
   input wire logic [15:0] coef_data_in,
   input wire logic cic_valid_in,
   input wire logic signed [15:0] cic_i_in,
   input wire logic signed [15:0] cic_q_in,
   input wire logic input_frame_sync,
   input wire logic serial_bit_en_in,
   input wire logic serial_din_in,
   output logic out_valid_out,
   output logic signed [15:0] inphase_out_a,
   output logic signed [15:0] quadrature_out_a,
   output logic signed [15:0] inphase_out_b,
   output logic signed [15:0] quadrature_out_b,
   output logic [11:0] dac_value_out,
   output fir_decimation_chain_pkg::pga_gain_type pga_gain_out,
   output logic powerdown_bit
);
   import fir_decimation_chain_pkg::*;

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic [15:0] fir1_ctrl_q;
   logic [15:0] fir2_ctrl_q;
   logic [15:0] fir2_shift_q;
   logic [15:0] gain_and_powerdown_control_q;
   pga_gain_type gain_q;

   response_type fir1_mode;
   logic [5:0] fir1_tap_count;
   logic [5:0] fir1_start;
   response_type fir2_mode;
   logic [6:0] tap_count;
   logic [6:0] coeff_start_location;
   logic interleave_enable;
   logic [3:0] shift_a;
   logic [3:0] shift_b;

   // Stage-one fields, shared A/B fields, interleave and A/B shifts
   assign fir1_mode = response_type'(fir1_ctrl_q[`FIR1_MODE_LSB +: 2]);
   assign fir1_tap_count = fir1_ctrl_q[`FIR1_NC_LSB +: 6];
   assign fir1_start = fir1_ctrl_q[`FIR1_BASE_LSB +: 6];
   assign fir2_mode = response_type'(fir2_ctrl_q[`FIR2_MODE_LSB +: 2]);
   assign tap_count = fir2_ctrl_q[`FIR2_NC_LSB +: 7];
   assign coeff_start_location = fir2_ctrl_q[`FIR2_BASE_LSB +: 7];
   assign interleave_enable = fir2_shift_q[`FIR2_ILV_BIT];
   assign shift_a = fir2_shift_q[`FIR2_SHA_LSB +: 4];
   assign shift_b = fir2_shift_q[`FIR2_SHB_LSB +: 4];

   // Takes effect on next output; coefficients untouched
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         fir1_ctrl_q <= `RST_REG16;
         fir2_ctrl_q <= `RST_REG16;
         fir2_shift_q <= `RST_REG16;
         gain_and_powerdown_control_q <= `RST_REG16;
      end
      else if (reg_wr_in)
      begin
         if (reg_addr_in == `ADDR_FIR1_CTRL)
            fir1_ctrl_q <= reg_wdata_in;
         if (reg_addr_in == `ADDR_FIR2_CTRL)
            fir2_ctrl_q <= reg_wdata_in;
         if (reg_addr_in == `ADDR_FIR2_SHIFT)
            fir2_shift_q <= reg_wdata_in;
         if (reg_addr_in == `ADDR_GAIN_PDN)
            gain_and_powerdown_control_q <= reg_wdata_in;
      end
   end

   // Reserved code 111 keeps the last legal gain
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         gain_q <= pga_gain_type'(`RST_GAIN);
      else if (reg_wr_in && reg_addr_in == `ADDR_GAIN_PDN
               && reg_wdata_in[`GAIN_LSB +: 3] != 3'h7)
         gain_q <= pga_gain_type'(reg_wdata_in[`GAIN_LSB +: 3]);
   end

   assign pga_gain_out = gain_q;
   assign powerdown_bit = gain_and_powerdown_control_q[`PDN_BIT];

   // ****************************************************************
   // Auxiliary DAC value
   // ****************************************************************
   logic [15:0] dac_shift_q;
   logic [4:0] dac_cnt_q;
   logic dac_armed_q;
   logic [11:0] dac_q;

   // Frame sync arms; next 16 enables shift MSB first
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dac_shift_q <= `RST_REG16;
         dac_cnt_q <= 5'h00;
         dac_armed_q <= 1'b0;
      end
      else if (serial_bit_en_in)
      begin
         if (input_frame_sync)
         begin
            dac_armed_q <= 1'b1;
            dac_cnt_q <= 5'h00;
         end
         else if (dac_armed_q)
         begin
            dac_shift_q <= {dac_shift_q[14:0], serial_din_in};
            dac_cnt_q <= dac_cnt_q + 5'h01;
            if (dac_cnt_q == `DAC_FRAME_BITS - 5'h01)
               dac_armed_q <= 1'b0;
         end
      end
   end

   logic serial_done;
   assign serial_done = serial_bit_en_in && dac_armed_q && !input_frame_sync
                        && dac_cnt_q == `DAC_FRAME_BITS - 5'h01;

   // Whichever path writes last wins; register write wins a tie
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         dac_q <= 12'h000;
      else if (reg_wr_in && reg_addr_in == `ADDR_DAC)
         dac_q <= reg_wdata_in[11:0];
      else if (serial_done)
         dac_q <= {dac_shift_q[10:0], serial_din_in};
   end

   assign dac_value_out = dac_q;

   // ****************************************************************
   // Memories
   // ****************************************************************
   logic signed [15:0] bank0 [`FIR1_DEPTH];
   logic signed [15:0] bank1 [`FIR2_DEPTH];
   logic signed [15:0] bank2 [`FIR2_DEPTH];

   always_ff @(posedge ref_clk_in)
   begin
      if (coef_wr_in && coef_bank_in == 2'h0)
         bank0[coef_addr_in[5:0]] <= coef_data_in;
      if (coef_wr_in && coef_bank_in == 2'h1)
         bank1[coef_addr_in] <= coef_data_in;
      if (coef_wr_in && coef_bank_in == 2'h2)
         bank2[coef_addr_in] <= coef_data_in;
   end

   // Sample histories, newest at index 0
   logic signed [15:0] h1_i [`FIR1_DEPTH];
   logic signed [15:0] h1_q [`FIR1_DEPTH];
   logic signed [15:0] h2_i [`FIR2_DEPTH];
   logic signed [15:0] h2_q [`FIR2_DEPTH];
   logic s1_valid;
   logic signed [15:0] s1_i_q;
   logic signed [15:0] s1_q_q;

   always_ff @(posedge ref_clk_in)
   begin
      if (cic_valid_in)
      begin
         h1_i[0] <= cic_i_in;
         h1_q[0] <= cic_q_in;
         for (int k = 1; k < `FIR1_DEPTH; k++)
         begin
            h1_i[k] <= h1_i[k - 1];
            h1_q[k] <= h1_q[k - 1];
         end
      end
      if (s1_valid)
      begin
         h2_i[0] <= s1_i_q;
         h2_q[0] <= s1_q_q;
         for (int k = 1; k < `FIR2_DEPTH; k++)
         begin
            h2_i[k] <= h2_i[k - 1];
            h2_q[k] <= h2_q[k - 1];
         end
      end
   end

   // ****************************************************************
   // Tap addressing: generic symmetric walk
   // ****************************************************************
   // Returns newest-side index, oldest-side index and pair flag.
   function automatic logic [15:0] tap_pick(input response_type m,
                                            input logic [6:0] n,
                                            input logic [6:0] k);
      logic [6:0] a;
      logic [6:0] b;
      logic pair;
      a = k;
      b = 7'h00;
      pair = 1'b0;
      unique case (m)
         RESP_ODD:
         begin
            b = 7'((2 * (n - 1)) - k);
            pair = (k != n - 7'h01);
         end
         RESP_EVEN:
         begin
            b = 7'((2 * n - 1) - k);
            pair = 1'b1;
         end
         RESP_HALFBAND:
         begin
            a = 7'(2 * k);
            b = 7'((4 * (n - 1)) - 2 * k);
            pair = (k != n - 7'h01);
         end
         RESP_ARBITRARY:
            pair = 1'b0;
      endcase
      return {1'b0, pair, a[6:0], b[6:0]};
   endfunction

   // Realised length
   function automatic logic [8:0] filt_len(input response_type m,
                                           input logic [6:0] n);
      logic [8:0] r;
      r = 9'h000;
      unique case (m)
         RESP_ODD: r = 9'(2 * (n - 1) + 1);
         RESP_EVEN: r = 9'(2 * n);
         RESP_HALFBAND: r = 9'(4 * (n - 1) + 1);
         RESP_ARBITRARY: r = 9'(n);
      endcase
      return r;
   endfunction

   // ****************************************************************
   // Stage one
   // ****************************************************************
   mac_state_type st1_q;
   logic phase1_q;
   logic [6:0] k1_q;
   logic signed [39:0] acc1_i_q;
   logic signed [39:0] acc1_q_q;
   logic [15:0] pk1;
   logic signed [15:0] c1;
   logic signed [16:0] s1_sum_i;
   logic signed [16:0] s1_sum_q;
   logic [8:0] len1;

   assign len1 = filt_len(fir1_mode, {1'b0, fir1_tap_count});
   assign pk1 = tap_pick(fir1_mode, {1'b0, fir1_tap_count}, k1_q);
   assign c1 = bank0[6'(fir1_start + k1_q[5:0])];
   // Longer than 62 taps falls outside the history
   assign s1_sum_i = (pk1[14] ? 17'(h1_i[pk1[5:0]]) : 17'h00000)
                     + 17'(h1_i[pk1[12:7]]);
   assign s1_sum_q = (pk1[14] ? 17'(h1_q[pk1[5:0]]) : 17'h00000)
                     + 17'(h1_q[pk1[12:7]]);

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st1_q <= ST_IDLE;
         phase1_q <= 1'b0;
         k1_q <= 7'h00;
         acc1_i_q <= '0;
         acc1_q_q <= '0;
      end
      else
      begin
         unique case (st1_q)
            ST_IDLE:
               if (cic_valid_in)
               begin
                  phase1_q <= ~phase1_q;
                  if (phase1_q && len1 <= 9'h03E)
                  begin
                     st1_q <= ST_RUN;
                     k1_q <= 7'h00;
                     acc1_i_q <= '0;
                     acc1_q_q <= '0;
                  end
               end
            ST_RUN:
            begin
               // One coefficient per clock
               acc1_i_q <= acc1_i_q + 40'(c1 * s1_sum_i);
               acc1_q_q <= acc1_q_q + 40'(c1 * s1_sum_q);
               k1_q <= k1_q + 7'h01;
               if (k1_q == {1'b0, fir1_tap_count} - 7'h01)
                  st1_q <= ST_DONE;
            end
            ST_DONE:
               st1_q <= ST_IDLE;
         endcase
      end
   end

   // Divide by 2^15 for unity gain
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s1_valid <= 1'b0;
         s1_i_q <= 16'h0000;
         s1_q_q <= 16'h0000;
      end
      else
      begin
         s1_valid <= (st1_q == ST_DONE);
         if (st1_q == ST_DONE)
         begin
            s1_i_q <= 16'(acc1_i_q >>> `FIR_SCALE);
            s1_q_q <= 16'(acc1_q_q >>> `FIR_SCALE);
         end
      end
   end

   // ****************************************************************
   // Stage two: A and B share the sequencer
   // ****************************************************************
   mac_state_type st2_q;
   logic phase2_q;
   logic [6:0] k2_q;
   logic signed [47:0] acc_ai_q;
   logic signed [47:0] acc_aq_q;
   logic signed [47:0] acc_bi_q;
   logic signed [47:0] acc_bq_q;
   logic [15:0] pk2;
   logic signed [15:0] ca;
   logic signed [15:0] cb;
   logic signed [16:0] s2_sum_i;
   logic signed [16:0] s2_sum_q;

   assign pk2 = tap_pick(fir2_mode, tap_count, k2_q);
   assign ca = bank1[7'(coeff_start_location + k2_q)];
   assign cb = bank2[7'(coeff_start_location + k2_q)];
   assign s2_sum_i = (pk2[14] ? 17'(h2_i[pk2[6:0]]) : 17'h00000)
                     + 17'(h2_i[pk2[13:7]]);
   assign s2_sum_q = (pk2[14] ? 17'(h2_q[pk2[6:0]]) : 17'h00000)
                     + 17'(h2_q[pk2[13:7]]);

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st2_q <= ST_IDLE;
         phase2_q <= 1'b0;
         k2_q <= 7'h00;
         acc_ai_q <= '0;
         acc_aq_q <= '0;
         acc_bi_q <= '0;
         acc_bq_q <= '0;
      end
      else
      begin
         unique case (st2_q)
            ST_IDLE:
               if (s1_valid)
               begin
                  phase2_q <= ~phase2_q;
                  if (phase2_q)
                  begin
                     st2_q <= ST_RUN;
                     k2_q <= 7'h00;
                     acc_ai_q <= '0;
                     acc_aq_q <= '0;
                     acc_bi_q <= '0;
                     acc_bq_q <= '0;
                  end
               end
            ST_RUN:
            begin
               acc_ai_q <= acc_ai_q + 48'(ca * s2_sum_i);
               acc_aq_q <= acc_aq_q + 48'(ca * s2_sum_q);
               acc_bi_q <= acc_bi_q + 48'(cb * s2_sum_i);
               acc_bq_q <= acc_bq_q + 48'(cb * s2_sum_q);
               k2_q <= k2_q + 7'h01;
               if (k2_q == tap_count - 7'h01)
                  st2_q <= ST_DONE;
            end
            ST_DONE:
               st2_q <= ST_IDLE;
         endcase
      end
   end

   // Interleave: A+B sums form one filter of summed A/B weights under shift A
   logic signed [47:0] sum_i;
   logic signed [47:0] sum_q;
   assign sum_i = acc_ai_q + acc_bi_q;
   assign sum_q = acc_aq_q + acc_bq_q;

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         out_valid_out <= 1'b0;
         inphase_out_a <= 16'h0000;
         quadrature_out_a <= 16'h0000;
         inphase_out_b <= 16'h0000;
         quadrature_out_b <= 16'h0000;
      end
      else
      begin
         out_valid_out <= (st2_q == ST_DONE);
         if (st2_q == ST_DONE && interleave_enable)
         begin
            inphase_out_a <= 16'(sum_i >>> (`FIR_SCALE + shift_a));
            quadrature_out_a <= 16'(sum_q >>> (`FIR_SCALE + shift_a));
            inphase_out_b <= 16'(sum_i >>> (`FIR_SCALE + shift_a));
            quadrature_out_b <= 16'(sum_q >>> (`FIR_SCALE + shift_a));
         end
         else if (st2_q == ST_DONE)
         begin
            inphase_out_a <= 16'(acc_ai_q >>> (`FIR_SCALE + shift_a));
            quadrature_out_a <= 16'(acc_aq_q >>> (`FIR_SCALE + shift_a));
            inphase_out_b <= 16'(acc_bi_q >>> (`FIR_SCALE + shift_b));
            quadrature_out_b <= 16'(acc_bq_q >>> (`FIR_SCALE + shift_b));
         end
      end
   end

   // ****************************************************************
   // Register read-back
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         reg_rdata_out <= 16'h0000;
      else
      begin
         unique case (reg_addr_in)
            `ADDR_FIR1_CTRL: reg_rdata_out <= fir1_ctrl_q;
            `ADDR_FIR2_CTRL: reg_rdata_out <= fir2_ctrl_q;
            `ADDR_FIR2_SHIFT: reg_rdata_out <= fir2_shift_q;
            `ADDR_GAIN_PDN: reg_rdata_out <= {gain_and_powerdown_control_q[15:5], gain_q,
                                             gain_and_powerdown_control_q[1:0]};
            `ADDR_DAC: reg_rdata_out <= {4'h0, dac_q};
            default: reg_rdata_out <= 16'h0000;
         endcase
      end
   end

endmodule

//--- sim/fir_decimation_chain_checker.sv
/*
 * Port checker of the FIR decimation chain.
 * Assumes binding onto the top module and one clock domain.
 */
`timescale 1ns/1ns
module fir_decimation_chain_checker
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic reg_wr_in,
   input wire logic [4:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic serial_bit_en_in,
   input wire logic out_valid_out,
   input wire logic signed [15:0] inphase_out_a,
   input wire logic signed [15:0] quadrature_out_a,
   input wire logic signed [15:0] inphase_out_b,
   input wire logic signed [15:0] quadrature_out_b,
   input wire logic [11:0] dac_value_out,
   input wire fir_decimation_chain_pkg::pga_gain_type pga_gain_out,
   input wire logic powerdown_bit
);
   import fir_decimation_chain_pkg::*;
   logic ilv_q;
   wire logic gain_wr = reg_wr_in && reg_addr_in == 5'h0C;
   wire logic dac_wr = reg_wr_in && reg_addr_in == 5'h0D;

   // Interleave flag as last written
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         ilv_q <= 1'b0;
      else if (reg_wr_in && reg_addr_in == 5'h0E)
         ilv_q <= reg_wdata_in[0];
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_GAIN_CODE: assert property (
      gain_wr && reg_wdata_in[4:2] != 3'h7 |=> pga_gain_out == $past(reg_wdata_in[4:2]))
      else $error("gain code not taken");
   AST_GAIN_RESERVED: assert property (
      gain_wr && reg_wdata_in[4:2] == 3'h7 |=> $stable(pga_gain_out))
      else $error("reserved gain code changed the gain");
   AST_GAIN_HOLD: assert property (
      !gain_wr |=> $stable(pga_gain_out))
      else $error("gain moved without a write");
   AST_POWERDOWN: assert property (
      gain_wr |=> powerdown_bit == $past(reg_wdata_in[0]))
      else $error("power-down bit not taken");
   AST_DAC_REG: assert property (
      dac_wr |=> dac_value_out == $past(reg_wdata_in[11:0]))
      else $error("register DAC value not taken");
   AST_DAC_SOURCE: assert property (
      $changed(dac_value_out) |-> $past(dac_wr) || $past(serial_bit_en_in))
      else $error("DAC value moved without a write");
   AST_VALID_PULSE: assert property (
      out_valid_out |=> !out_valid_out)
      else $error("output valid longer than one cycle");
   AST_OUT_HOLD: assert property (
      !out_valid_out |-> $stable(inphase_out_a) && $stable(quadrature_out_b))
      else $error("outputs moved without valid");
   AST_INTERLEAVE_COPY: assert property (
      out_valid_out && ilv_q |-> inphase_out_b == inphase_out_a
         && quadrature_out_b == quadrature_out_a)
      else $error("interleaved B output differs from A");
endmodule

bind fir_decimation_chain fir_decimation_chain_checker i_chk
(
   .ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in),
   .reg_wr_in(reg_wr_in),
   .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in),
   .serial_bit_en_in(serial_bit_en_in),
   .out_valid_out(out_valid_out),
   .inphase_out_a(inphase_out_a),
   .quadrature_out_a(quadrature_out_a),
   .inphase_out_b(inphase_out_b),
   .quadrature_out_b(quadrature_out_b),
   .dac_value_out(dac_value_out),
   .pga_gain_out(pga_gain_out),
   .powerdown_bit(powerdown_bit)
);

//--- sim/cic_dac_source.sv
/*
 * Far side model: CIC sample source and serial DAC word sender.
 * Assumes the bench calls its tasks; drives on the falling edge.
 */
`timescale 1ns/1ns
module cic_dac_source
(
   input wire logic ref_clk_in,
   output logic cic_valid_out = 1'b0,
   output logic signed [15:0] cic_i_out = 16'h0000,
   output logic signed [15:0] cic_q_out = 16'h0000,
   output logic frame_sync_out = 1'b0,
   output logic bit_en_out = 1'b0,
   output logic din_out = 1'b0
);
   // Samples 16 cycles apart keep both tap limits for counts of 2 and 1
   task automatic stream(input int n, input logic signed [15:0] xi, xq);
      repeat (n)
      begin
         @(negedge ref_clk_in);
         cic_valid_out = 1'b1;
         cic_i_out = xi;
         cic_q_out = xq;
         @(negedge ref_clk_in);
         cic_valid_out = 1'b0;
         cic_i_out = ~xi;
         cic_q_out = ~xq;
         repeat (14) @(negedge ref_clk_in);
      end
   endtask

   // Never overlaps a register write to the DAC
   task automatic dac_frame(input logic [15:0] w);
      @(negedge ref_clk_in);
      bit_en_out = 1'b1;
      frame_sync_out = 1'b1;
      @(negedge ref_clk_in);
      bit_en_out = 1'b0;
      frame_sync_out = 1'b0;
      for (int b = 15; b >= 0; b--)
      begin
         @(negedge ref_clk_in);
         bit_en_out = 1'b1;
         din_out = w[b];
         @(negedge ref_clk_in);
         bit_en_out = 1'b0;
      end
      din_out = ~w[0];
   endtask
endmodule

//--- sim/fir_decimation_chain_bench.sv
/*
 * Self-checking bench of the FIR decimation chain.
 * Assumes the checker is bound and the far side model drives the stream.
 */
`timescale 1ns/1ns
module fir_decimation_chain_bench;
   import fir_decimation_chain_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic reg_wr_in = 1'b0;
   logic [4:0] reg_addr_in = 5'h00;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic coef_wr_in = 1'b0;
   logic [1:0] coef_bank_in = 2'h0;
   logic [6:0] coef_addr_in = 7'h00;
   logic [15:0] coef_data_in = 16'h0000;
   logic cic_valid_in, input_frame_sync, serial_bit_en_in, serial_din_in;
   logic signed [15:0] cic_i_in, cic_q_in, ai, aq, bi, bq;
   logic [15:0] reg_rdata_out;
   logic out_valid_out, powerdown_bit;
   logic [11:0] dac_value_out;
   pga_gain_type pga_gain_out;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_out = 0;

   always #5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (out_valid_out === 1'b1) n_out++;

   fir_decimation_chain i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .coef_wr_in(coef_wr_in), .coef_bank_in(coef_bank_in),
      .coef_addr_in(coef_addr_in), .coef_data_in(coef_data_in), .cic_valid_in(cic_valid_in),
      .cic_i_in(cic_i_in), .cic_q_in(cic_q_in), .input_frame_sync(input_frame_sync),
      .serial_bit_en_in(serial_bit_en_in), .serial_din_in(serial_din_in),
      .out_valid_out(out_valid_out), .inphase_out_a(ai), .quadrature_out_a(aq),
      .inphase_out_b(bi), .quadrature_out_b(bq), .dac_value_out(dac_value_out),
      .pga_gain_out(pga_gain_out), .powerdown_bit(powerdown_bit));
   cic_dac_source i_src (.ref_clk_in(ref_clk_in), .cic_valid_out(cic_valid_in),
      .cic_i_out(cic_i_in), .cic_q_out(cic_q_in), .frame_sync_out(input_frame_sync),
      .bit_en_out(serial_bit_en_in), .din_out(serial_din_in));

   // ************
   // Shared tasks
   // ************
   task automatic chk(input string what, input logic [15:0] exp, got);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge ref_clk_in);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge ref_clk_in);
      reg_wr_in = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(negedge ref_clk_in);
      reg_addr_in = a;
      @(negedge ref_clk_in);
      chk("reg_rdata_out", exp, reg_rdata_out);
   endtask

   task automatic coef(input logic [1:0] b, input logic [6:0] a, input logic [15:0] d);
      @(negedge ref_clk_in);
      coef_wr_in = 1'b1;
      coef_bank_in = b;
      coef_addr_in = a;
      coef_data_in = d;
      @(negedge ref_clk_in);
      coef_wr_in = 1'b0;
   endtask

   // Steady input through a stage-one weight sum, then one stage-two tap
   function automatic logic [15:0] e(input int x, sum, c2, sh);
      int s1;
      s1 = (x * sum) >>> 15;
      return 16'((s1 * c2) >>> (15 + sh));
   endfunction

   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ************
   // Scenarios
   // ************
   task automatic t_gain();
      logic [2:0] codes [7] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3};
      foreach (codes[k])
      begin
         wr(5'h0C, {11'h000, codes[k], 2'h0});
         chk("pga_gain_out", {13'h0000, codes[k]}, {13'h0000, pga_gain_out});
         rd(5'h0C, {11'h000, codes[k], 2'h0});
      end
      wr(5'h0C, 16'h001D);
      chk("pga_gain_out", 16'h0003, {13'h0000, pga_gain_out});
      chk("powerdown_bit", 16'h0001, {15'h0000, powerdown_bit});
      wr(5'h0C, 16'h0000);
      chk("powerdown_bit", 16'h0000, {15'h0000, powerdown_bit});
      rd(5'h1F, 16'h0000);
   endtask

   task automatic t_dac();
      wr(5'h0D, 16'hABCD);
      chk("dac_value_out", 16'h0BCD, {4'h0, dac_value_out});
      i_src.dac_frame(16'hF234);
      repeat (2) @(negedge ref_clk_in);
      chk("dac_value_out", 16'h0234, {4'h0, dac_value_out});
      wr(5'h0D, 16'h0567);
      chk("dac_value_out", 16'h0567, {4'h0, dac_value_out});
   endtask

   // Base 4 in bank zero; A and B share stage-two fields, B shifted by one
   task automatic t_modes();
      int sums [4] = '{16384, 24576, 16384, 12288};
      coef(2'h0, 7'h04, 16'h1000);
      coef(2'h0, 7'h05, 16'h2000);
      coef(2'h1, 7'h00, 16'h7FFF);
      coef(2'h2, 7'h00, 16'h7FFF);
      wr(5'h0B, 16'hC080);
      wr(5'h0E, 16'h0100);
      for (int m = 0; m < 4; m++)
      begin
         wr(5'h0A, {m[1:0], 14'h0084});
         n_out = 0;
         i_src.stream(24, 16'sd1000, 16'sd2000);
         chk("out_valid_out count", 16'h0006, 16'(n_out));
         chk("inphase_out_a", e(1000, sums[m], 32767, 0), ai);
         chk("quadrature_out_a", e(2000, sums[m], 32767, 0), aq);
         chk("inphase_out_b", e(1000, sums[m], 32767, 1), bi);
         chk("quadrature_out_b", e(2000, sums[m], 32767, 1), bq);
      end
   endtask

   task automatic t_interleave();
      wr(5'h0E, 16'h0001);
      i_src.stream(8, 16'sd1000, 16'sd2000);
      chk("inphase_out_a", e(1000, 12288, 65534, 0), ai);
      chk("inphase_out_b", e(1000, 12288, 65534, 0), bi);
      chk("quadrature_out_b", e(2000, 12288, 65534, 0), bq);
   endtask

   initial
   begin
      repeat (16) @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      @(negedge ref_clk_in);
      t_gain();
      t_dac();
      t_modes();
      t_interleave();
      report_and_stop();
   end

   initial
   begin
      #300000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
